/* File: hw/mhp_port.sv */
// Eight-bit parallel microprocessor host port with two handshake styles
// Overview of operation
// - Mode pin high picks strobe-ack handshake, low picks separate strobes.
// - Shared strobe is read strobe, or data strobe in acknowledge mode.
// - In acknowledge mode direction high requests a read, low a write; separate mode uses it as the active-low write strobe.
// - Completion shown on open-drain acknowledge pin; host provides pull-up.
// - Separate mode: ready rises within 9 clocks of write strobe fall.
// - Separate mode: reads of any address finish within 13 clocks.
// - Acknowledge mode: write acknowledged low within 9 clocks of strobe.
// - Acknowledge mode: read acknowledged low within 13 clocks of strobe.
// - Reset holds the port and its state idle until released.
`timescale 1ns/1ns
`include "mhp_consts.svh"

module mhp_port (
   input  wire logic             CLK_SYS,
   input  wire logic             RST,
   // Host pins
   input  wire logic             MODE_SEL,
   input  wire logic             CS_N,
   input  wire logic             DATA_STROBE_N,
   input  wire logic             RW_DIR,
   input  wire mhp_pkg::mhp_addr_t ADDR,
   input  wire mhp_pkg::mhp_data_t DATA_I,
   output mhp_pkg::mhp_data_t    DATA_O,
   output logic                  DATA_OE,
   output logic                  TRANSFER_ACK_N_O,
   output logic                  TRANSFER_ACK_N_OE,
   // Internal location side
   output logic                  LOC_WR_STB,
   output logic                  LOC_RD_STB,
   output mhp_pkg::mhp_addr_t    LOC_ADDR,
   output mhp_pkg::mhp_data_t    LOC_WDATA,
   input  wire mhp_pkg::mhp_data_t LOC_RDATA,
   input  wire logic             LOC_DONE,
   output logic                  LOC_LATE
);
   import mhp_pkg::*;

   mhp_state_t state_reg;
   mhp_state_t state_next;
   logic       mode_reg;
   logic       mode_next;
   logic       read_reg;
   logic       read_next;
   mhp_addr_t  addr_reg;
   mhp_addr_t  addr_next;
   mhp_data_t  wdata_reg;
   mhp_data_t  wdata_next;
   mhp_data_t  rdata_reg;
   mhp_data_t  rdata_next;
   logic       done_seen_reg;
   logic       done_seen_next;
   logic       issue_reg;
   logic       issue_next;
   logic       late_reg;
   logic       late_next;
   logic       ack_oe_reg;
   logic       ack_oe_next;
   logic       data_oe_reg;
   logic       data_oe_next;

   // Previous pin levels for falling edge detection
   logic       strobe_q_reg;
   logic       rw_q_reg;

   logic       strobe_fall;
   logic       rw_fall;
   logic       start;
   logic       start_read;
   logic       min_met;
   logic       expired;
   logic       finish;
   logic       released;

   // Pins are synchronous, so one register suffices for edges
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         strobe_q_reg <= 1'b1;
         rw_q_reg     <= 1'b1;
      end else begin
         strobe_q_reg <= DATA_STROBE_N;
         rw_q_reg     <= RW_DIR;
      end
   end

   assign strobe_fall = strobe_q_reg & ~DATA_STROBE_N;
   assign rw_fall     = rw_q_reg & ~RW_DIR;

   // Start decode per handshake style, only while selected
   always_comb begin
      start      = 1'b0;
      start_read = 1'b0;
      if (!CS_N && state_reg == MHP_IDLE) begin
         if (MODE_SEL == `MHP_MODE_STROBE_ACK) begin
            // Data strobe qualifies both directions
            start      = strobe_fall;
            start_read = RW_DIR == `MHP_DIR_READ;
         end else begin
            // Read strobe and active-low write strobe are separate
            start      = strobe_fall | rw_fall;
            start_read = strobe_fall;
         end
      end
   end

   // Bounds the wait on the internal side
   mhp_deadline u_deadline (
      .CLK_SYS (CLK_SYS),
      .RST     (RST),
      .START   (start),
      .IS_READ (start_read),
      .MIN_MET (min_met),
      .EXPIRED (expired)
   );

   // Internal done may arrive early; hold answer until the minimum time
   assign finish = (min_met && (done_seen_reg || LOC_DONE)) || expired;

   // Host lets go of the strobe that opened the access
   always_comb begin
      if (mode_reg == `MHP_MODE_STROBE_ACK || read_reg) begin
         released = DATA_STROBE_N;
      end else begin
         released = RW_DIR;
      end
   end

   // Access sequencing
   always_comb begin
      state_next     = state_reg;
      mode_next      = mode_reg;
      read_next      = read_reg;
      addr_next      = addr_reg;
      wdata_next     = wdata_reg;
      rdata_next     = rdata_reg;
      done_seen_next = done_seen_reg;
      issue_next     = 1'b0;
      late_next      = 1'b0;
      case (state_reg)
         MHP_IDLE: begin
            // Mode is only followed between accesses
            mode_next = MODE_SEL;
            if (start) begin
               read_next      = start_read;
               addr_next      = ADDR;
               wdata_next     = DATA_I;
               done_seen_next = 1'b0;
               issue_next     = 1'b1;
               state_next     = MHP_ACCESS;
            end
         end
         MHP_ACCESS: begin
            if (LOC_DONE) begin
               done_seen_next = 1'b1;
            end
            if (LOC_DONE && read_reg && !done_seen_reg) begin
               rdata_next = LOC_RDATA;
            end
            if (finish) begin
               // Forced finish flags an internal side that was too slow
               late_next  = expired && !(done_seen_reg || LOC_DONE);
               state_next = MHP_DONE;
            end
         end
         MHP_DONE: begin
            if (released) begin
               state_next = MHP_IDLE;
            end
         end
         default: begin
            state_next = MHP_IDLE;
         end
      endcase
   end

   // Acknowledge pin and data drivers
   always_comb begin
      ack_oe_next  = 1'b0;
      data_oe_next = 1'b0;
      if (mode_next == `MHP_MODE_STROBE_ACK) begin
         // Pulled low once the access has completed
         ack_oe_next = state_next == MHP_DONE;
      end else begin
         // Held low while busy; released pin reads as ready
         ack_oe_next = state_next == MHP_ACCESS;
      end
      // Drive only while the selected read is still strobed
      data_oe_next = state_next == MHP_DONE && read_next && !CS_N &&
                     !DATA_STROBE_N;
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         state_reg     <= MHP_IDLE;
         mode_reg      <= `MHP_MODE_SEPARATE;
         read_reg      <= 1'b0;
         addr_reg      <= '0;
         wdata_reg     <= '0;
         rdata_reg     <= `MHP_RDATA_RST;
         done_seen_reg <= 1'b0;
         issue_reg     <= 1'b0;
         late_reg      <= 1'b0;
         ack_oe_reg    <= 1'b0;
         data_oe_reg   <= 1'b0;
      end else begin
         state_reg     <= state_next;
         mode_reg      <= mode_next;
         read_reg      <= read_next;
         addr_reg      <= addr_next;
         wdata_reg     <= wdata_next;
         rdata_reg     <= rdata_next;
         done_seen_reg <= done_seen_next;
         issue_reg     <= issue_next;
         late_reg      <= late_next;
         ack_oe_reg    <= ack_oe_next;
         data_oe_reg   <= data_oe_next;
      end
   end

   // Open drain: the pin only ever pulls low
   assign TRANSFER_ACK_N_O  = 1'b0;
   assign TRANSFER_ACK_N_OE = ack_oe_reg;
   assign DATA_O            = rdata_reg;
   assign DATA_OE           = data_oe_reg;

   // Internal strobes are single-cycle pulses
   assign LOC_WR_STB = issue_reg & ~read_reg;
   assign LOC_RD_STB = issue_reg & read_reg;
   assign LOC_ADDR   = addr_reg;
   assign LOC_WDATA  = wdata_reg;
   assign LOC_LATE   = late_reg;
endmodule : mhp_port

/* File: hw/mhp_consts.svh */
// Constants for the microprocessor host port
`ifndef MHP_CONSTS_SVH
`define MHP_CONSTS_SVH

// Port widths
`define MHP_ADDR_W 3
`define MHP_DATA_W 8

// Mode pin levels
`define MHP_MODE_SEPARATE 1'b0
`define MHP_MODE_STROBE_ACK 1'b1

// Direction pin levels
`define MHP_DIR_READ 1'b1
`define MHP_DIR_WRITE 1'b0

// Access latency bounds, in clock periods, strobe fall to completion
`define MHP_WR_LAT_MIN 4
`define MHP_WR_LAT_MAX 9
`define MHP_RD_LAT_MIN 8
`define MHP_RD_LAT_MAX 13

// Sampling costs one cycle, the registered answer one more
`define MHP_PIPE_CYCLES 2

// Width of the latency counter
`define MHP_CNT_W 4

// Reset value of the captured read data
`define MHP_RDATA_RST 8'h00

`endif

/* File: hw/mhp_pkg.sv */
// Types shared by the microprocessor host port
package mhp_pkg;
   typedef logic [2:0] mhp_addr_t;
   typedef logic [7:0] mhp_data_t;
   typedef logic [3:0] mhp_cnt_t;

   typedef enum {
      MHP_IDLE,
      MHP_ACCESS,
      MHP_DONE
   } mhp_state_t;
endpackage : mhp_pkg

/* File: hw/mhp_deadline.sv */
// Latency counter that bounds each host access
`timescale 1ns/1ns
`include "mhp_consts.svh"

module mhp_deadline (
   input  wire logic             CLK_SYS,
   input  wire logic             RST,
   input  wire logic             START,
   input  wire logic             IS_READ,
   output logic                  MIN_MET,
   output logic                  EXPIRED
);
   import mhp_pkg::*;

   // Counts seen from the first sampled cycle of the strobe
   localparam mhp_cnt_t WR_MIN_CNT =
      mhp_cnt_t'(`MHP_WR_LAT_MIN - `MHP_PIPE_CYCLES);
   localparam mhp_cnt_t WR_MAX_CNT =
      mhp_cnt_t'(`MHP_WR_LAT_MAX - `MHP_PIPE_CYCLES);
   localparam mhp_cnt_t RD_MIN_CNT =
      mhp_cnt_t'(`MHP_RD_LAT_MIN - `MHP_PIPE_CYCLES);
   localparam mhp_cnt_t RD_MAX_CNT =
      mhp_cnt_t'(`MHP_RD_LAT_MAX - `MHP_PIPE_CYCLES);

   mhp_cnt_t cnt_reg;
   mhp_cnt_t cnt_next;
   logic     rd_reg;
   logic     rd_next;

   // Restart on every access, saturate at the top
   always_comb begin
      cnt_next = cnt_reg;
      rd_next  = rd_reg;
      if (START) begin
         cnt_next = '0;
         rd_next  = IS_READ;
      end else if (cnt_reg != '1) begin
         cnt_next = cnt_reg + mhp_cnt_t'(1);
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         cnt_reg <= '1;
         rd_reg  <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         rd_reg  <= rd_next;
      end
   end

   // Reads get the longer window
   assign MIN_MET = cnt_reg >= (rd_reg ? RD_MIN_CNT : WR_MIN_CNT);
   assign EXPIRED = cnt_reg >= (rd_reg ? RD_MAX_CNT : WR_MAX_CNT);
endmodule : mhp_deadline

/* File: tb/mhp_port_chk.sv */
// Timing checker for the host port pins
`timescale 1ns/1ns
module mhp_port_chk (
   input wire logic CLK_SYS,
   input wire logic RST,
   input wire logic MODE_SEL,
   input wire logic CS_N,
   input wire logic DATA_STROBE_N,
   input wire logic DATA_OE,
   input wire logic TRANSFER_ACK_N_O,
   input wire logic TRANSFER_ACK_N_OE,
   input wire logic LOC_WR_STB,
   input wire logic LOC_RD_STB
);
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RST);
   property p_od; TRANSFER_ACK_N_O == 1'b0; endproperty
   a_od: assert property (p_od)
      else $error("ack pin drives high");
   property p_rst; $fell(RST) |-> !DATA_OE && !TRANSFER_ACK_N_OE
      && !LOC_WR_STB && !LOC_RD_STB; endproperty
   a_rst: assert property (p_rst)
      else $error("outputs active after reset");
   property p_doe; DATA_OE |-> $past(!CS_N && !DATA_STROBE_N); endproperty
   a_doe: assert property (p_doe)
      else $error("data driven outside selected read");
   property p_ackw; LOC_WR_STB && MODE_SEL |-> ##[3:8] TRANSFER_ACK_N_OE;
   endproperty
   a_ackw: assert property (p_ackw)
      else $error("write ack late");
   property p_ackr; LOC_RD_STB && MODE_SEL |-> ##[7:12] TRANSFER_ACK_N_OE;
   endproperty
   a_ackr: assert property (p_ackr)
      else $error("read ack late");
   property p_rdyw; LOC_WR_STB && !MODE_SEL |->
      TRANSFER_ACK_N_OE ##[3:8] !TRANSFER_ACK_N_OE; endproperty
   a_rdyw: assert property (p_rdyw)
      else $error("write ready late");
   property p_rdyr; LOC_RD_STB && !MODE_SEL |->
      TRANSFER_ACK_N_OE ##[7:12] !TRANSFER_ACK_N_OE; endproperty
   a_rdyr: assert property (p_rdyr)
      else $error("read ready late");
   property p_rdq; LOC_RD_STB |-> $past(!DATA_STROBE_N && !CS_N); endproperty
   a_rdq: assert property (p_rdq)
      else $error("read without strobe");
endmodule : mhp_port_chk

/* File: tb/mhp_loc_model.sv */
// Responder standing in for the internal locations
`timescale 1ns/1ns
module mhp_loc_model (
   input wire logic               clk,
   input wire logic               slow,
   input wire logic               wr_stb,
   input wire logic               rd_stb,
   input wire mhp_pkg::mhp_addr_t addr,
   input wire mhp_pkg::mhp_data_t wdata,
   output mhp_pkg::mhp_data_t     rdata,
   output logic                   done
);
   mhp_pkg::mhp_data_t mem [8] = '{default: 8'h00};
   initial done = 1'b0;
   initial rdata = 8'h00;
   // Answer fast, or past the port's deadline when slow is set
   always @(posedge clk) if (wr_stb || rd_stb) begin
      if (wr_stb) mem[addr] <= wdata;
      repeat (slow ? 14 : $urandom_range(4)) @(posedge clk);
      done <= 1'b1;
      rdata <= mem[addr];
      @(posedge clk);
      done <= 1'b0;
      rdata <= ~mem[addr];
   end
endmodule : mhp_loc_model

/* File: tb/testbench.sv */
// Self-checking bench for the host port
`timescale 1ns/1ns
module testbench;
   import mhp_pkg::*;
   logic clk = 1'b0, rst = 1'b1, mode = 1'b0, cs_n = 1'b1;
   logic ds_n = 1'b1, dir = 1'b1, doe, ack_o, ack_oe, wstb, rstb;
   logic done, oe_q = 1'b0, late, slow = 1'b0;
   mhp_addr_t a = 3'h0, la;
   mhp_data_t din = 8'h00, dout, wd, rd, sh [8] = '{default: 8'h00};
   mhp_data_t exp_q [$];
   int fail_count = 0, compares = 0, nstb = 0;
   // Open-drain pin with board pull-up
   wire ack_n = ack_oe ? ack_o : 1'b1;
   always #50 clk = ~clk;
   mhp_port i_dut (.CLK_SYS(clk), .RST(rst), .MODE_SEL(mode), .CS_N(cs_n),
      .DATA_STROBE_N(ds_n), .RW_DIR(dir), .ADDR(a), .DATA_I(din),
      .DATA_O(dout), .DATA_OE(doe), .TRANSFER_ACK_N_O(ack_o),
      .TRANSFER_ACK_N_OE(ack_oe), .LOC_WR_STB(wstb), .LOC_RD_STB(rstb),
      .LOC_ADDR(la), .LOC_WDATA(wd), .LOC_RDATA(rd), .LOC_DONE(done),
      .LOC_LATE(late));
   mhp_loc_model i_loc (.clk(clk), .slow(slow), .wr_stb(wstb), .rd_stb(rstb),
      .addr(la), .wdata(wd), .rdata(rd), .done(done));
   task chk(input string n, input mhp_data_t e, input mhp_data_t g);
      compares++;
      if (g !== e) begin
         fail_count++;
         $display("mismatch %s exp %h got %h", n, e, g);
      end
   endtask : chk
   task end_sim;
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : end_sim
   // One host access; wait for ack (mode 1) or ready (mode 0)
   task acc(input logic m, input logic r, input mhp_addr_t ad,
            input mhp_data_t d);
      int n;
      n = 0;
      mode <= m;
      cs_n <= 1'b0;
      a <= ad;
      din <= d;
      dir <= m ? r : 1'b1;
      @(posedge clk);
      if (r) exp_q.push_back(sh[ad]);
      else sh[ad] = d;
      if (r || m) ds_n <= 1'b0;
      else dir <= 1'b0;
      if (!m) repeat (3) @(posedge clk);
      do @(posedge clk); while (ack_n !== !m && ++n < 30);
      if (n >= 30) fail_count++;
      chk("late flag", 8'(slow), 8'(late));
      ds_n <= 1'b1;
      dir <= 1'b1;
      cs_n <= 1'b1;
      repeat (3) @(posedge clk);
   endtask : acc
   // Result watcher: each read data drive takes the oldest note
   always @(posedge clk) begin
      oe_q <= doe;
      if (wstb === 1'b1 || rstb === 1'b1) nstb++;
      if (doe === 1'b1 && oe_q !== 1'b1) begin
         if (exp_q.size() == 0) chk("read count", 8'h00, 8'h01);
         else chk("read data", exp_q.pop_front(), dout);
      end
   end
   initial begin
      void'($urandom(32'h543c));
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      for (int m = 0; m < 2; m++) begin
         for (int i = 0; i < 8; i++) acc(m[0], 1'b0, i[2:0], 8'($urandom));
         for (int i = 7; i >= 0; i--) acc(m[0], 1'b1, i[2:0], 8'h00);
         // Internal side too slow: port must finish at its deadline
         slow <= 1'b1;
         acc(m[0], 1'b0, 3'h6, 8'($urandom));
         slow <= 1'b0;
         // Let the late answer drain before the next access
         repeat (20) @(posedge clk);
         $display("test mode %0d done", m);
      end
      // Strobes while deselected must leave no trace
      nstb = 0;
      ds_n <= 1'b0;
      dir <= 1'b0;
      repeat (4) @(posedge clk);
      ds_n <= 1'b1;
      dir <= 1'b1;
      repeat (4) @(posedge clk);
      chk("stray strobes", 8'h00, 8'(nstb));
      $display("test deselect done");
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      acc(1'b1, 1'b1, 3'h5, 8'h00);
      $display("test reset done");
      end_sim;
   end
   initial begin
      #400000;
      fail_count++;
      end_sim;
   end
endmodule : testbench
bind mhp_port mhp_port_chk u_chk (.CLK_SYS, .RST, .MODE_SEL, .CS_N,
   .DATA_STROBE_N, .DATA_OE, .TRANSFER_ACK_N_O, .TRANSFER_ACK_N_OE,
   .LOC_WR_STB, .LOC_RD_STB);
